// ==== sau_serial_port_unit.sv ====
// Asynchronous serial transceiver with AXI4-Lite register access
`timescale 1ns/100ps
module sau_serial_port_unit import sau_pkg::*; #(
    parameter logic [7:0] DIV_RESET = RST_DIV
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write channels
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read channels
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Serial line and clock pin
    output logic             txd,
    input  wire logic        rxd,
    input  wire logic        serial_clock_pin_i,
    output logic             serial_clock_pin_o,
    output logic             serial_clock_pin_oe,
    // Interrupt requests
    output logic             rx_full_irq,
    output logic             tx_empty_irq,
    output logic             tx_end_irq
);
    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [7:0]  mode;
        logic [7:0]  ctrl;
        logic [7:0]  tx_data_reg;
        logic [7:0]  rx_data_reg;
        logic [7:0]  div;
        logic [7:0]  bcnt;
        logic        ck_s1, ck_s2, ck_s3;
        logic        rx_s1, rx_s2, rx_prev;
        logic        tx_empty_flag, rx_full_flag, overrun_flag, framing_error_flag, parity_error_flag, tx_end_flag, mpbr, mpbt;
        sau_tx_st_t  tx_st;
        logic [3:0]  tx_ph;
        logic [3:0]  tx_pos;
        logic [7:0]  tx_shift_reg;
        logic        tx_extra;
        logic        txd;
        sau_rx_st_t  rx_st;
        logic [3:0]  rx_ph;
        logic [3:0]  rx_pos;
        logic [7:0]  rx_shift_reg;
        logic        rx_extra;
        logic        sck_o, sck_oe;
        logic        irq_rx, irq_tx, irq_te;
        logic        aw_got, w_got;
        logic [7:0]  aw_addr;
        logic [7:0]  w_data;
        logic        w_strb0;
        logic        awready, wready, bvalid;
        logic [1:0]  bresp;
        logic        arready, rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } sau_state_t;

    sau_state_t s;
    sau_state_t next_s;

    ////////////////////////////////////////////////////////////////////////////
    // Frame shape from the mode register
    logic [3:0] n_data;
    logic       has_extra;
    logic [3:0] last_pos;
    logic       ext_clk;
    assign n_data    = s.mode[M_CHR] ? 4'h7 : 4'h8;
    assign has_extra = s.mode[M_MP] | s.mode[M_PE];
    // Start + data + extra + stops, minus one
    assign last_pos  = n_data + {3'h0, has_extra} + {3'h0, s.mode[M_STOP]} + 4'h1;
    assign ext_clk   = s.ctrl[C_CLOCK_ENABLE_HIGH];

    // Parity over data bits; odd select inverts it
    function automatic logic par_of(input logic [7:0] d, input logic odd);
        par_of = (^d) ^ odd;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // All next-state logic
    always_comb begin
        logic       tick;
        logic       tx_bnd;
        logic       rx_smp;
        logic       wr;
        logic [7:0] wv;
        logic       bit_v;
        logic [7:0] dmask;
        tick   = 1'b0;
        tx_bnd = 1'b0;
        rx_smp = 1'b0;
        wr     = 1'b0;
        wv     = 8'h00;
        bit_v  = 1'b1;
        dmask  = 8'h00;
        next_s = s;

        // Pin synchronisers; first stages feed only the second
        next_s.ck_s1   = serial_clock_pin_i;
        next_s.ck_s2   = s.ck_s1;
        next_s.ck_s3   = s.ck_s2;
        next_s.rx_s1   = rxd;
        next_s.rx_s2   = s.rx_s1;

        // Sixteen-times tick: external pin edge or internal divider
        if (ext_clk) begin
            tick        = s.ck_s2 & ~s.ck_s3;
            next_s.bcnt = 8'h00;
        end else if (s.bcnt >= s.div) begin
            tick        = 1'b1;
            next_s.bcnt = 8'h00;
        end else begin
            next_s.bcnt = s.bcnt + 8'h01;
        end

        // AXI write: address and data accepted in either order
        if (awvalid && s.awready) begin
            next_s.aw_got  = 1'b1;
            next_s.aw_addr = awaddr;
        end
        if (wvalid && s.wready) begin
            next_s.w_got   = 1'b1;
            next_s.w_data  = wdata[7:0];
            next_s.w_strb0 = wstrb[0];
        end
        if (bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end
        if (next_s.aw_got && next_s.w_got && !s.bvalid) begin
            wr             = next_s.w_strb0;
            wv             = next_s.w_data;
            next_s.aw_got  = 1'b0;
            next_s.w_got   = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = RESP_OK;
            unique case (next_s.aw_addr)
                OFS_MODE:   if (wr) next_s.mode = wv;
                OFS_CTRL:   if (wr) next_s.ctrl = wv;
                OFS_TXDATA: if (wr) next_s.tx_data_reg  = wv;
                OFS_DIV:    if (wr) next_s.div  = wv;
                OFS_STATUS: if (wr) begin
                    // Writing 0 clears a flag, tx_end_flag through the tx_empty_flag bit; writing 1 leaves it; mpbt takes the written bit
                    if (!wv[S_TX_EMPTY_FLAG]) begin
                        next_s.tx_empty_flag = 1'b0;
                        next_s.tx_end_flag = 1'b0;
                    end
                    if (!wv[S_RX_FULL_FLAG]) next_s.rx_full_flag = 1'b0;
                    if (!wv[S_OER])  next_s.overrun_flag  = 1'b0;
                    if (!wv[S_FER])  next_s.framing_error_flag  = 1'b0;
                    if (!wv[S_PER])  next_s.parity_error_flag  = 1'b0;
                    next_s.mpbt = wv[S_MPBT];
                end
                OFS_RXDATA: ;
                default:    next_s.bresp = RESP_ERR;
            endcase
        end

        // AXI read: one outstanding, plain reads have no side effect
        if (rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
        if (arvalid && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = RESP_OK;
            next_s.rdata  = 32'h0000_0000;
            unique case (araddr)
                OFS_MODE:   next_s.rdata[7:0] = s.mode;
                OFS_CTRL:   next_s.rdata[7:0] = s.ctrl;
                OFS_TXDATA: next_s.rdata[7:0] = s.tx_data_reg;
                OFS_RXDATA: next_s.rdata[7:0] = s.rx_data_reg;
                OFS_DIV:    next_s.rdata[7:0] = s.div;
                OFS_STATUS: next_s.rdata[7:0] = {s.tx_empty_flag, s.rx_full_flag, s.overrun_flag, s.framing_error_flag,
                                                  s.parity_error_flag, s.tx_end_flag, s.mpbr, s.mpbt};
                default:    next_s.rresp = RESP_ERR;
            endcase
        end

        // Transmitter: free-running bit phase; hardware sets win over clears
        if (tick) begin
            next_s.tx_ph = s.tx_ph + 4'h1;
            tx_bnd       = (s.tx_ph == PH_LAST);
        end
        if (tx_bnd && s.tx_st == TX_RUN) begin
            if (s.tx_pos == last_pos) begin
                if (s.ctrl[C_TE] && !next_s.tx_empty_flag) begin
                    next_s.tx_shift_reg      = s.tx_data_reg;
                    next_s.tx_extra = s.mode[M_MP] ? s.mpbt
                                    : par_of(s.tx_data_reg & dmask_of(s.mode[M_CHR]), s.mode[M_PM]);
                    next_s.tx_empty_flag     = 1'b1;
                    next_s.tx_pos   = 4'h0;
                end else begin
                    next_s.tx_end_flag  = 1'b1;
                    next_s.tx_st = TX_IDLE;
                end
            end else begin
                next_s.tx_pos = s.tx_pos + 4'h1;
            end
        end else if (tx_bnd && s.ctrl[C_TE] && !next_s.tx_empty_flag) begin
            next_s.tx_shift_reg      = s.tx_data_reg;
            next_s.tx_extra = s.mode[M_MP] ? s.mpbt
                            : par_of(s.tx_data_reg & dmask_of(s.mode[M_CHR]), s.mode[M_PM]);
            next_s.tx_empty_flag     = 1'b1;
            next_s.tx_end_flag     = 1'b0;
            next_s.tx_pos   = 4'h0;
            next_s.tx_st    = TX_RUN;
        end
        if (!s.ctrl[C_TE]) begin
            next_s.tx_empty_flag  = 1'b1;
            next_s.tx_st = TX_IDLE;
        end

        // Line level for the current frame position
        if (next_s.tx_st == TX_RUN) begin
            if (next_s.tx_pos == 4'h0) begin
                bit_v = 1'b0;
            end else if (next_s.tx_pos <= n_data) begin
                bit_v = next_s.tx_shift_reg[3'(next_s.tx_pos - 4'h1)];
            end else if (has_extra && next_s.tx_pos == n_data + 4'h1) begin
                bit_v = next_s.tx_extra;
            end
        end
        next_s.txd = bit_v;

        // Receiver: start edge, then sample at mid-bit
        dmask = dmask_of(s.mode[M_CHR]);
        if (tick) begin
            next_s.rx_prev = s.rx_s2;
            next_s.rx_ph   = s.rx_ph + 4'h1;
            rx_smp         = (s.rx_ph == PH_LAST);
        end
        unique case (s.rx_st)
            RX_IDLE: if (tick && s.rx_prev && !s.rx_s2 && s.ctrl[C_RE]
                         && !(s.overrun_flag | s.framing_error_flag | s.parity_error_flag)) begin
                next_s.rx_st = RX_START;
                next_s.rx_ph = 4'h1;
            end
            RX_START: if (tick && s.rx_ph == PH_MID) begin
                // Eighth pulse after the falling edge
                if (s.rx_s2) begin
                    next_s.rx_st = RX_IDLE;
                end else begin
                    next_s.rx_st  = RX_RUN;
                    next_s.rx_ph  = 4'h0;
                    next_s.rx_pos = 4'h1;
                    next_s.rx_shift_reg    = 8'h00;
                end
            end
            RX_RUN: if (rx_smp) begin
                next_s.rx_pos = s.rx_pos + 4'h1;
                if (s.rx_pos <= n_data) begin
                    next_s.rx_shift_reg[3'(s.rx_pos - 4'h1)] = s.rx_s2;
                end else if (has_extra && s.rx_pos == n_data + 4'h1) begin
                    next_s.rx_extra = s.rx_s2;
                end else begin
                    // First stop bit only; a second stop is left to idle
                    next_s.rx_st = RX_IDLE;
                    if (s.rx_full_flag) begin
                        next_s.overrun_flag = 1'b1;
                    end else begin
                        next_s.rx_data_reg = s.rx_shift_reg & dmask;
                        if (s.mode[M_MP]) next_s.mpbr = s.rx_extra;
                        if (!s.rx_s2) begin
                            next_s.framing_error_flag = 1'b1;
                        end else if (!s.mode[M_MP] && s.mode[M_PE]
                                     && par_of(s.rx_shift_reg & dmask, s.mode[M_PM]) != s.rx_extra) begin
                            next_s.parity_error_flag = 1'b1;
                        end else begin
                            next_s.rx_full_flag = 1'b1;
                        end
                    end
                end
            end
        endcase
        // Disabling the receiver only stops the frame in progress
        if (!s.ctrl[C_RE]) begin
            next_s.rx_st = RX_IDLE;
        end

        // Clock pin role from mode and enables
        if (s.mode[M_COM]) begin
            next_s.sck_oe = ~s.ctrl[C_CLOCK_ENABLE_HIGH];
            next_s.sck_o  = 1'b1;
        end else begin
            next_s.sck_oe = ~s.ctrl[C_CLOCK_ENABLE_HIGH] & s.ctrl[C_CLOCK_ENABLE_LOW];
            // Low for phases 0-7, rises at phase 8, the bit centre
            next_s.sck_o  = next_s.tx_ph[3];
        end

        // Interrupt request levels
        next_s.irq_rx = next_s.rx_full_flag & s.ctrl[C_RIE];
        next_s.irq_tx = next_s.tx_empty_flag & s.ctrl[C_TIE];
        next_s.irq_te = next_s.tx_end_flag & s.ctrl[C_TX_END_IRQ_ENABLE];

        // Ready outputs as flops
        next_s.awready = ~next_s.aw_got & ~next_s.bvalid;
        next_s.wready  = ~next_s.w_got & ~next_s.bvalid;
        next_s.arready = ~next_s.rvalid;
    end

    // Data mask for seven or eight data bits
    function automatic logic [7:0] dmask_of(input logic chr);
        dmask_of = chr ? 8'h7F : 8'hFF;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s         <= '0;
            s.mode    <= RST_MODE;
            s.ctrl    <= RST_CTRL;
            s.div     <= DIV_RESET;
            s.tx_empty_flag    <= 1'b1;
            s.txd     <= 1'b1;
            s.sck_o   <= 1'b1;
            s.rx_prev <= 1'b1;
            s.tx_st   <= TX_IDLE;
            s.rx_st   <= RX_IDLE;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from flops
    assign awready             = s.awready;
    assign wready              = s.wready;
    assign bvalid              = s.bvalid;
    assign bresp               = s.bresp;
    assign arready             = s.arready;
    assign rvalid              = s.rvalid;
    assign rdata               = s.rdata;
    assign rresp               = s.rresp;
    assign txd                 = s.txd;
    assign serial_clock_pin_o  = s.sck_o;
    assign serial_clock_pin_oe = s.sck_oe;
    assign rx_full_irq         = s.irq_rx;
    assign tx_empty_irq        = s.irq_tx;
    assign tx_end_irq          = s.irq_te;
endmodule

// ==== sau_pkg.sv ====
// Constants, field positions and state types of the serial port unit
// Notes on behaviour
// - Tick source comes from the high clock-enable bit; pin role from mode bit and both clock-enable bits; sync internal drives pin.
// - Async internal: pin idle without clock_enable_low, else bit-rate clock out.
// - Driven-out async clock rises at the centre of each data bit.
// - Good frame moved to rx_data_reg sets rx_full_flag; rx_irq_enable raises request.
// - Move from tx_data_reg into tx_shift_reg sets tx_empty_flag; tx_irq_enable requests.
// - tx_empty_flag still set at last bit sets tx_end_flag; enable raises request.
// - Line idles high; a falling edge on the idle line that is still low at mid-bit is taken as a start bit.
// - Frame: low start, data LSB first, optional parity or multiproc bit, high stops.
// - Receiver syncs to start falling edge, samples on eighth of sixteen ticks.
// - Twelve formats: 7/8 data, parity, multiproc bit replacing parity, one/two stops.
// - Clearing tx_enable sets tx_empty_flag.
// - Clearing rx_enable keeps receive flags and rx_data_reg unchanged.
// - Transmitter and receiver are independent and double-buffered, full duplex.
// - Parity checked against odd select; only the first stop bit is checked.
// - Frame ending with rx_full_flag set flags overrun, byte dropped; other errors transfer.
// - No reception while any receive error flag is set.
package sau_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_MODE   = 8'h00;
    localparam logic [7:0] OFS_CTRL   = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_TXDATA = 8'h0C;
    localparam logic [7:0] OFS_RXDATA = 8'h10;
    localparam logic [7:0] OFS_DIV    = 8'h14;
    // serial_mode_reg fields
    localparam int M_COM  = 7;
    localparam int M_CHR  = 6;
    localparam int M_PE   = 5;
    localparam int M_PM   = 4;
    localparam int M_STOP = 3;
    localparam int M_MP   = 2;
    // serial_control_reg fields
    localparam int C_TIE  = 7;
    localparam int C_RIE  = 6;
    localparam int C_TE   = 5;
    localparam int C_RE   = 4;
    localparam int C_TX_END_IRQ_ENABLE = 2;
    localparam int C_CLOCK_ENABLE_HIGH = 1;
    localparam int C_CLOCK_ENABLE_LOW = 0;
    // serial_status_reg fields
    localparam int S_TX_EMPTY_FLAG = 7;
    localparam int S_RX_FULL_FLAG = 6;
    localparam int S_OER  = 5;
    localparam int S_FER  = 4;
    localparam int S_PER  = 3;
    localparam int S_TX_END_FLAG = 2;
    localparam int S_MPBR = 1;
    localparam int S_MPBT = 0;
    // Reset values and timing counts
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_DIV  = 8'h0F;
    localparam logic [3:0] PH_LAST  = 4'hF;
    localparam logic [3:0] PH_MID   = 4'h7;
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    typedef enum logic [0:0] {TX_IDLE, TX_RUN} sau_tx_st_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_RUN} sau_rx_st_t;
endpackage

// ==== sau_serial_port_unit_monitor.sv ====
// Port-level assertions for the serial port unit
`timescale 1ns/100ps
module sau_serial_port_unit_monitor (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus handshakes
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    // Line and clock pin
    input wire logic txd,
    input wire logic serial_clock_pin_o,
    input wire logic serial_clock_pin_oe
);
    // One clock domain, so reset masks every check once here
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////
    // Register bus: answers and locks
    property p_wr_answer;
        awvalid && awready && wvalid && wready |=> bvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write answer missing");
    property p_wr_lock;
        bvalid |-> !awready && !wready;
    endproperty
    a_wr_lock: assert property (p_wr_lock) else $error("write accepted while answer pends");
    property p_wr_release;
        bvalid && bready |=> !bvalid;
    endproperty
    a_wr_release: assert property (p_wr_release) else $error("write answer held too long");
    property p_rd_answer;
        arvalid && arready |=> rvalid && !arready;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer missing");
    property p_rd_release;
        rvalid && rready |=> !rvalid;
    endproperty
    a_rd_release: assert property (p_rd_release) else $error("read answer held too long");
    ////////////////////////////////////////////////////////////////
    // Serial line and clock pin
    property p_idle_mark;
        $rose(aresetn) |-> txd && !serial_clock_pin_oe;
    endproperty
    a_idle_mark: assert property (p_idle_mark) else $error("line not at mark after reset");
    // Divider is zero in the bench, so a start bit spans sixteen clocks
    property p_start_len;
        $fell(txd) |=> !txd [*7];
    endproperty
    a_start_len: assert property (p_start_len) else $error("start bit too short");
    property p_clk_mid;
        serial_clock_pin_oe && $changed(txd) |-> ##[6:10] $rose(serial_clock_pin_o);
    endproperty
    a_clk_mid: assert property (p_clk_mid) else $error("pin clock not rising mid-bit");
endmodule
bind sau_serial_port_unit sau_serial_port_unit_monitor i_sau_serial_port_unit_monitor (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
    .wready(wready), .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
    .rvalid(rvalid), .rready(rready), .txd(txd), .serial_clock_pin_o(serial_clock_pin_o),
    .serial_clock_pin_oe(serial_clock_pin_oe)
);

// ==== sau_remote_model.sv ====
// Remote serial device: sends and captures frames of sixteen clocks a bit
`timescale 1ns/100ps
module sau_remote_model (
    // Clock
    input wire logic aclk,
    // Line side
    input wire logic txd,
    output logic     rxd,
    output logic     ext_clk
);
    // Line rests at mark; external clock runs free and never stops
    initial begin
        rxd = 1'b1;
        ext_clk = 1'b0;
    end
    always @(posedge aclk) ext_clk <= ~ext_clk;
    ////////////////////////////////////////////////////////////////
    // Start bit, then the given bits LSB first, stops included by caller
    task automatic send(input logic [11:0] bits, input int nb);
        rxd <= 1'b0;
        repeat (16) @(posedge aclk);
        for (int i = 0; i < nb; i++) begin
            rxd <= bits[i];
            repeat (16) @(posedge aclk);
        end
        rxd <= 1'b1;
    endtask
    // Waits for a start bit, then samples each bit at its centre
    task automatic capture(output logic [11:0] bits, input int nb);
        bits = 12'h000;
        for (int w = 0; w < 400 && txd !== 1'b0; w++) @(posedge aclk);
        repeat (8) @(posedge aclk);
        for (int i = 0; i < nb; i++) begin
            repeat (16) @(posedge aclk);
            bits[i] = txd;
        end
    endtask
endmodule

// ==== sau_serial_port_unit_tb.sv ====
// Register-level testbench of the serial port unit
`timescale 1ns/100ps
module sau_serial_port_unit_tb import sau_pkg::*; ;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        txd, rxd, ext_clk, clk_o, clk_oe, rx_irq, tx_irq, end_irq;
    logic        chr, pe, pm, st2, mp;
    logic [1:0]  bresp, rresp, rr;
    logic [3:0]  wstrb;
    logic [7:0]  awaddr, araddr, d, dm;
    logic [11:0] e, rb, cap;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  ckt [4] = '{4'h0, 4'h3, 4'h4, 4'h9};
    int          num_errors, n_compared, nd, nb;
    // 250 MHz clock
    always #2 aclk = ~aclk;
    // Divider at zero gives a tick every clock and keeps frames short
    sau_serial_port_unit #(.DIV_RESET(8'h00)) i_sau_serial_port_unit (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .txd(txd), .rxd(rxd), .serial_clock_pin_i(ext_clk), .serial_clock_pin_o(clk_o),
        .serial_clock_pin_oe(clk_oe), .rx_full_irq(rx_irq), .tx_empty_irq(tx_irq),
        .tx_end_irq(end_irq));
    sau_remote_model i_sau_remote_model (.aclk(aclk), .txd(txd), .rxd(rxd), .ext_clk(ext_clk));
    ////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] ev, input logic [31:0] got);
        n_compared++;
        if (got !== ev) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, ev, got);
        end
    endtask
    task automatic finish_test();
        $display("errors %0d comparisons %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // One bus transfer; request held until each channel is taken
    task automatic axi(input logic w, input logic [7:0] a, input logic [7:0] v);
        int n;
        awaddr <= a;
        araddr <= a;
        wdata <= {24'h000000, v};
        wstrb <= 4'hF;
        awvalid <= w;
        wvalid <= w;
        bready <= w;
        arvalid <= !w;
        rready <= !w;
        for (n = 0; n < 200; n++) begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (arready === 1'b1) arvalid <= 1'b0;
            if ((w ? bvalid : rvalid) === 1'b1) break;
        end
        rd = rdata;
        rr = w ? bresp : rresp;
        bready <= 1'b0;
        rready <= 1'b0;
        if (n == 200) begin
            check("bus answer", 32'h1, 32'h0);
            finish_test();
        end
        @(posedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        axi(1'b1, a, v);
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] ev,
                        input logic [31:0] m);
        axi(1'b0, a, 8'h00);
        check(nm, ev, rd & m);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        num_errors = 0;
        n_compared = 0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // Reset values and an unmapped place
        rchk("status", OFS_STATUS, 32'h80, 32'hF8);
        rchk("control", OFS_CTRL, {24'h0, RST_CTRL}, 32'hFFFFFFFF);
        rchk("unmapped", 8'h18, 32'h0, 32'hFFFFFFFF);
        check("unmapped resp", {30'h0, RESP_ERR}, {30'h0, rr});
        // All twelve formats, both directions at once
        for (int f = 0; f < 12; f++) begin
            mp = (f >= 8);
            chr = mp ? f[1] : f[2];
            pe = mp | f[1];
            pm = f[2] ^ f[0];
            st2 = f[0];
            d = 8'hC3 ^ {f[3:0], f[3:0]};
            dm = chr ? 8'h7F : 8'hFF;
            nd = chr ? 7 : 8;
            e = chr ? {5'h1F, d[6:0]} : {4'hF, d};
            if (pe) e[nd] = mp ? 1'b0 : ((^(d & dm)) ^ pm);
            nb = nd + int'(pe) + 1 + int'(st2);
            rb = e;
            if (mp) rb[nd] = 1'b1;
            wr(OFS_CTRL, 8'h00);
            wr(OFS_MODE, {1'b0, chr, pe, pm, st2, mp, 2'b00});
            wr(OFS_CTRL, 8'hF5);
            wr(OFS_TXDATA, d);
            wr(OFS_STATUS, 8'h7E);
            fork
                i_sau_remote_model.capture(cap, nb);
                i_sau_remote_model.send(rb, nb);
            join
            for (int n = 0; n < 100 && end_irq !== 1'b1; n++) @(posedge aclk);
            check("tx frame", {20'h0, e & ~(12'hFFF << nb)}, {20'h0, cap});
            check("end irq", 32'h1, {31'h0, end_irq});
            check("empty irq", 32'h1, {31'h0, tx_irq});
            check("full irq", 32'h1, {31'h0, rx_irq});
            rchk("rx data", OFS_RXDATA, {24'h0, d & dm}, 32'hFFFFFFFF);
            rchk("status", OFS_STATUS, {24'h0, 6'h31, mp, 1'b0} << 2 >> 2 | 32'hC4, 32'hFE);
            wr(OFS_STATUS, 8'hBE);
        end
        // Overrun, blocked reception, receiver disable, framing and parity errors
        wr(OFS_CTRL, 8'h00);
        wr(OFS_MODE, 8'h00);
        wr(OFS_CTRL, 8'h50);
        i_sau_remote_model.send(12'hF11, 9);
        i_sau_remote_model.send(12'hF22, 9);
        rchk("overrun", OFS_STATUS, 32'h60, 32'h78);
        rchk("kept data", OFS_RXDATA, 32'h11, 32'hFF);
        wr(OFS_STATUS, 8'hB8);
        i_sau_remote_model.send(12'hF33, 9);
        rchk("blocked", OFS_RXDATA, 32'h11, 32'hFF);
        wr(OFS_CTRL, 8'h40);
        rchk("flags kept", OFS_STATUS, 32'h20, 32'h78);
        wr(OFS_STATUS, 8'h80);
        wr(OFS_CTRL, 8'h50);
        i_sau_remote_model.send(12'hE44, 9);
        rchk("framing", OFS_STATUS, 32'h10, 32'h78);
        rchk("framing data", OFS_RXDATA, 32'h44, 32'hFF);
        wr(OFS_STATUS, 8'h80);
        wr(OFS_CTRL, 8'h00);
        wr(OFS_MODE, 8'h20);
        wr(OFS_CTRL, 8'h50);
        i_sau_remote_model.send(12'hF55 | 12'h100, 10);
        rchk("parity", OFS_STATUS, 32'h08, 32'h78);
        // Transmit abort with a byte pending in the buffer
        wr(OFS_STATUS, 8'h80);
        wr(OFS_CTRL, 8'h00);
        wr(OFS_MODE, 8'h00);
        wr(OFS_CTRL, 8'h20);
        // Only bit 1 is low, so the abort never cuts a falling edge short
        wr(OFS_TXDATA, 8'hFD);
        wr(OFS_STATUS, 8'h7E);
        i_sau_remote_model.capture(cap, 2);
        check("abort bits", 32'h1, {20'h0, cap});
        wr(OFS_TXDATA, 8'h5A);
        wr(OFS_STATUS, 8'h7E);
        rchk("pending", OFS_STATUS, 32'h00, 32'h80);
        wr(OFS_CTRL, 8'h00);
        rchk("empty on disable", OFS_STATUS, 32'h80, 32'h80);
        check("line idle", 32'h1, {31'h0, txd});
        // Clock pin role for four selections: async none, async out, async external, sync internal
        for (int c = 0; c < 4; c++) begin
            wr(OFS_CTRL, 8'h00);
            wr(OFS_MODE, {ckt[c][3], 7'h00});
            wr(OFS_CTRL, {6'h00, ckt[c][2:1]});
            check("pin enable", {31'h0, ckt[c][0]}, {31'h0, clk_oe});
        end
        finish_test();
    end
endmodule
